// *** rtl/cwd_pkg.sv ***
// Shared constants and types for the crystal-clocked watchdog
package cwd_pkg;

    localparam logic [7:0] CWD_ADDR_CTRL = 8'hC0;

    localparam int CWD_BIT_WR   = 0;
    localparam int CWD_BIT_EN   = 1;
    localparam int CWD_BIT_FLAG = 2;
    localparam int CWD_BIT_RESP = 3;
    localparam int CWD_PRE_LSB  = 4;
    localparam int CWD_PRE_MSB  = 7;

    localparam logic [3:0] CWD_PRE_RST  = 4'h7;
    localparam logic [3:0] CWD_PRE_MAXT = 4'h7;
    localparam logic [3:0] CWD_PRE_AUTO = 4'h8;
    localparam logic [3:0] CWD_PRE_DL   = 4'h9;
    localparam logic       CWD_EN_RST   = 1'b1;
    localparam logic       CWD_RESP_RST = 1'b0;

    // Crystal rate and the longest timeout; shorter ones halve from it
    localparam int CWD_XTAL_HZ     = 32768;
    localparam int CWD_T_MAX_S     = 2;
    localparam int CWD_TICKS_MAX   = CWD_T_MAX_S * CWD_XTAL_HZ;
    localparam int CWD_TICKS_MIN   = CWD_TICKS_MAX >> 7;
    localparam logic [16:0] CWD_TICKS_MIN_W = 17'(CWD_TICKS_MIN);

    typedef struct packed {
        logic [3:0] pre;
        logic       resp;
        logic       flag;
        logic       en;
        logic       armed;
        logic [7:0] rdata;
        logic       rst_o;
        logic       dl_o;
        logic       irq_o;
    } cwd_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        expire;
    } cwd_cnt_state_t;

    // Low counter bits that must all be ones at the last tick of a period
    function automatic logic [15:0] cwd_pre_mask(input logic [3:0] pre);
        logic [16:0] m;
        m = (CWD_TICKS_MIN_W << pre) - 17'h0_0001;
        return m[15:0];
    endfunction : cwd_pre_mask

endpackage : cwd_pkg

// *** rtl/cwd_cnt_if.sv ***
// Link between the watchdog control logic and its tick counter
`timescale 1ns/1ps
`default_nettype none
interface cwd_cnt_if;
    logic       clear;
    logic       run;
    logic       tick;
    logic [3:0] pre;
    logic       expire;

    modport ctl (output clear, output run, output tick, output pre,
                 input expire);
    modport cnt (input clear, input run, input tick, input pre,
                 output expire);
endinterface : cwd_cnt_if
`default_nettype wire

// *** rtl/cwd_counter.sv ***
// Sixteen-bit crystal-tick counter with selectable expiry bit
`timescale 1ns/1ps
`default_nettype none
module cwd_counter (
    input  wire logic ref_clk,
    input  wire logic resetn,
    cwd_cnt_if.cnt    c
);
    import cwd_pkg::*;

    cwd_cnt_state_t st_ff;
    cwd_cnt_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.expire = 1'b0;
        if (c.clear || !c.run) begin
            nxt_st.cnt = 16'h0000;
        end else if (c.tick) begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
            // Period ends when the selected low bits roll over
            if (c.pre <= CWD_PRE_MAXT &&
                (st_ff.cnt & cwd_pre_mask(c.pre)) == cwd_pre_mask(c.pre)) begin
                nxt_st.expire = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign c.expire = st_ff.expire;

    chk_expire_needs_tick: assert property (@(posedge ref_clk)
        disable iff (!resetn) st_ff.expire |-> $past(c.tick) && $past(c.run))
        else $error("Expiry without a crystal tick");

endmodule : cwd_counter
`default_nettype wire

// *** rtl/cwd_watchdog.sv ***
// Watchdog control register, write guard, protection and expiry response
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       instr_end,
    input  wire logic       xtal_tick,
    input  wire logic       flash_prot_n,
    output logic            wdt_reset,
    output logic            wdt_download,
    output logic            wdt_irq
);
    import cwd_pkg::*;

    cwd_state_t st_ff;
    cwd_state_t nxt_st;
    cwd_cnt_if  cif ();
    logic       hit_wr;
    logic       hit_rd;
    logic       prot;
    logic       imm;
    logic       clear_c;

    // A strobe is for this block only at the control register address
    function automatic logic ctrl_hit(input logic       strobe,
                                      input logic [7:0] addr);
        return strobe && (addr == CWD_ADDR_CTRL);
    endfunction : ctrl_hit

    cwd_counter u_counter (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .c       (cif.cnt)
    );

    assign hit_wr = ctrl_hit(sfr_wr, sfr_addr);
    assign hit_rd = ctrl_hit(sfr_rd, sfr_addr);
    assign prot   = !flash_prot_n;
    // Codes 8 and 9 fire without waiting for the counter
    assign imm    = st_ff.en &&
                    (st_ff.pre == CWD_PRE_AUTO || st_ff.pre == CWD_PRE_DL);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_o = 1'b0;
        nxt_st.dl_o  = 1'b0;
        nxt_st.irq_o = 1'b0;
        nxt_st.rdata = 8'h00;
        clear_c      = 1'b0;

        if (hit_rd) begin
            nxt_st.rdata = {st_ff.pre, st_ff.resp, st_ff.flag,
                            st_ff.en, st_ff.armed};
        end

        if (hit_wr && st_ff.armed) begin
            nxt_st.pre   = sfr_wdata[CWD_PRE_MSB:CWD_PRE_LSB];
            nxt_st.resp  = sfr_wdata[CWD_BIT_RESP];
            nxt_st.flag  = st_ff.flag & sfr_wdata[CWD_BIT_FLAG];
            nxt_st.en    = sfr_wdata[CWD_BIT_EN];
            nxt_st.armed = 1'b0;
            if (sfr_wdata[CWD_BIT_EN]) begin
                clear_c = 1'b1;
            end
        end else if (hit_wr) begin
            // Unarmed writes may only arm the guard
            nxt_st.armed = sfr_wdata[CWD_BIT_WR];
        end else if (instr_end && st_ff.armed) begin
            nxt_st.armed = 1'b0;
        end

        if (prot) begin
            nxt_st.en   = 1'b1;
            nxt_st.resp = 1'b0;
        end

        // Hardware set wins over a software clear in the same cycle
        if (cif.expire || imm) begin
            nxt_st.flag = 1'b1;
        end

        if ((cif.expire && !st_ff.resp) || imm) begin
            nxt_st.rst_o = 1'b1;
            nxt_st.dl_o  = imm && (st_ff.pre == CWD_PRE_DL);
            // Watchdog reset restores defaults but keeps the flag
            nxt_st.pre   = CWD_PRE_RST;
            nxt_st.en    = CWD_EN_RST;
            nxt_st.resp  = CWD_RESP_RST;
            nxt_st.armed = 1'b0;
            clear_c      = 1'b1;
        end else if (cif.expire) begin
            nxt_st.irq_o = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff       <= '0;
            st_ff.pre   <= CWD_PRE_RST;
            st_ff.en    <= CWD_EN_RST;
            st_ff.resp  <= CWD_RESP_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cif.clear = clear_c;
    assign cif.run   = st_ff.en;
    assign cif.tick  = xtal_tick;
    assign cif.pre   = st_ff.pre;

    assign sfr_rdata    = st_ff.rdata;
    assign wdt_reset    = st_ff.rst_o;
    assign wdt_download = st_ff.dl_o;
    assign wdt_irq      = st_ff.irq_o;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_prot_forces_bits: assert property (
        prot ##1 prot |-> st_ff.en && !st_ff.resp)
        else $error("Protection did not force enable and response");

    chk_unarmed_write_ignored: assert property (
        hit_wr && !st_ff.armed && !prot && !cif.expire && !imm
        |=> st_ff.pre == $past(st_ff.pre) && st_ff.en == $past(st_ff.en)
            && st_ff.resp == $past(st_ff.resp))
        else $error("Unguarded write changed the register");

    chk_guard_dropped: assert property (
        st_ff.armed && instr_end && !hit_wr |=> !st_ff.armed)
        else $error("Write permission survived another instruction");

    chk_armed_write_lands: assert property (
        hit_wr && st_ff.armed && !cif.expire && !imm
        |=> st_ff.pre == $past(sfr_wdata[CWD_PRE_MSB:CWD_PRE_LSB]))
        else $error("Guarded write did not update timeout field");

    chk_disable_stops: assert property (
        hit_wr && st_ff.armed && !sfr_wdata[CWD_BIT_EN] && !prot
        && !cif.expire && !imm |=> !st_ff.en ##1 !cif.expire)
        else $error("Watchdog kept running after disable");

    chk_expiry_reset: assert property (
        cif.expire && !st_ff.resp |=> wdt_reset && !wdt_irq
        && st_ff.pre == CWD_PRE_RST && st_ff.en)
        else $error("Expiry with reset response gave no reset");

    chk_expiry_irq: assert property (
        cif.expire && st_ff.resp && !imm |=> wdt_irq && !wdt_reset)
        else $error("Expiry with interrupt response gave no interrupt");

    chk_flag_sticky: assert property (
        (cif.expire || imm) |=> st_ff.flag ##1 (st_ff.flag
        || $past(hit_wr && st_ff.armed && !sfr_wdata[CWD_BIT_FLAG])))
        else $error("Timeout flag not set or lost");

    chk_immediate_reset: assert property (
        st_ff.en && st_ff.pre == CWD_PRE_DL |=> wdt_reset && wdt_download)
        else $error("Download code gave no immediate reset");

    chk_refresh_clears: assert property (
        hit_wr && st_ff.armed && sfr_wdata[CWD_BIT_EN] |-> cif.clear)
        else $error("Enable write did not clear the counter");

    chk_auto_reset: assert property (
        st_ff.en && st_ff.pre == CWD_PRE_AUTO |=> wdt_reset && !wdt_download)
        else $error("Automatic reset code gave no plain reset");

    chk_invalid_code_quiet: assert property (
        st_ff.pre > CWD_PRE_DL |=> !cif.expire)
        else $error("Invalid timeout code produced an expiry");

    chk_disabled_quiet: assert property (
        !st_ff.en |=> !cif.expire)
        else $error("Disabled watchdog produced an expiry");

    chk_flag_cleared: assert property (
        hit_wr && st_ff.armed && !sfr_wdata[CWD_BIT_FLAG] && !cif.expire
        && !imm |=> !st_ff.flag)
        else $error("Software zero did not clear the timeout flag");

    chk_prot_write_held: assert property (
        prot && hit_wr && st_ff.armed |=> st_ff.en && !st_ff.resp)
        else $error("Protected write changed enable or response");

    chk_irq_keeps_mode: assert property (
        cif.expire && st_ff.resp && !imm && !hit_wr && !prot
        |=> st_ff.resp && st_ff.flag)
        else $error("Interrupt response changed the watchdog mode");

    chk_reset_single: assert property (
        wdt_reset |=> !wdt_reset)
        else $error("Watchdog reset pulse longer than one cycle");

    chk_irq_single: assert property (
        wdt_irq |=> !wdt_irq)
        else $error("Watchdog interrupt pulse longer than one cycle");

    chk_rdata_idle: assert property (
        !hit_rd |=> sfr_rdata == 8'h00)
        else $error("Read data not returned to zero");

    chk_armed_consumed: assert property (
        hit_wr && st_ff.armed |=> !st_ff.armed)
        else $error("Write permission survived the guarded write");

    cov_guarded_write: cover property (
        hit_wr && !st_ff.armed && sfr_wdata[CWD_BIT_WR] ##1
        hit_wr && st_ff.armed);
    cov_timeout_reset: cover property (cif.expire && !st_ff.resp);
    cov_timeout_irq: cover property (cif.expire && st_ff.resp);
    cov_guard_lost: cover property (st_ff.armed && instr_end && !hit_wr);
    cov_download_reset: cover property (imm && st_ff.pre == CWD_PRE_DL);

endmodule : cwd_watchdog
`default_nettype wire

// *** sim/cwd_watchdog_test.sv ***
// Self-checking bench for the crystal-clocked watchdog
`timescale 1ns/1ps
`default_nettype none
module cwd_watchdog_test;
    import cwd_pkg::*;
    typedef struct {logic [7:0] wd; logic [7:0] rd;} cwd_row_t;
    logic       ref_clk, resetn, sfr_wr, sfr_rd, instr_end;
    logic       xtal_tick, flash_prot_n, wdt_reset, wdt_download, wdt_irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic       hit_irq, hit_dl;
    int         error_cnt, n_tests, cyc, at;
    cwd_row_t   rows [4];

    cwd_watchdog dut (.ref_clk(ref_clk), .resetn(resetn),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .instr_end(instr_end),
        .xtal_tick(xtal_tick), .flash_prot_n(flash_prot_n),
        .wdt_reset(wdt_reset), .wdt_download(wdt_download),
        .wdt_irq(wdt_irq));

    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_wr = 1;
        sfr_addr = a;
        sfr_wdata = d;
        instr_end = 1;
        @(negedge ref_clk);
        sfr_wr = 0;
        instr_end = 0;
    endtask : wr

    task automatic gwr(input logic [7:0] d);
        wr(CWD_ADDR_CTRL, 8'h01);
        wr(CWD_ADDR_CTRL, d);
    endtask : gwr

    task automatic rd(input string nm, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_rd = 1;
        sfr_addr = CWD_ADDR_CTRL;
        @(negedge ref_clk);
        sfr_rd = 0;
        check(nm, 16'(sfr_rdata), 16'(exp));
    endtask : rd

    // Ticks every cycle until the first reset or interrupt pulse
    task automatic run(input int max);
        at = 0;
        hit_irq = 0;
        hit_dl = 0;
        xtal_tick = 1;
        for (int i = 1; i <= max && at == 0; i++) begin
            @(negedge ref_clk);
            if (wdt_reset === 1'b1 || wdt_irq === 1'b1) begin
                at = i;
                hit_irq = wdt_irq;
                hit_dl = wdt_download;
            end
        end
        xtal_tick = 0;
    endtask : run

    task automatic pin_reset;
        resetn = 0;
        repeat (4) @(negedge ref_clk);
        resetn = 1;
    endtask : pin_reset

    initial begin
        {sfr_wr, sfr_rd, instr_end, xtal_tick, sfr_addr, sfr_wdata} = '0;
        {error_cnt, n_tests, cyc} = '0;
        flash_prot_n = 1;
        rows = '{'{8'h50, 8'h50}, '{8'h32, 8'h32}, '{8'h6A, 8'h6A},
                 '{8'hF0, 8'hF0}};
        pin_reset();
        foreach (rows[i]) begin
            gwr(rows[i].wd);
            rd("row", rows[i].rd);
        end
        $display("test rows done");
        pin_reset();
        rd("reset", 8'h72);
        wr(CWD_ADDR_CTRL, 8'h50);
        rd("unarmed", 8'h72);
        wr(CWD_ADDR_CTRL, 8'h01);
        rd("armed", 8'h73);
        instr_end = 1;
        @(negedge ref_clk);
        instr_end = 0;
        wr(CWD_ADDR_CTRL, 8'h50);
        rd("dropped", 8'h72);
        $display("test guard done");
        gwr(8'hF2);
        run(600);
        check("invalid", 16'(at), 16'h0000);
        gwr(8'h00);
        run(600);
        check("disabled", 16'(at), 16'h0000);
        gwr(8'h02);
        run(400);
        gwr(8'h02);
        run(400);
        check("refresh", 16'(at), 16'h0000);
        run(200);
        check("expiry", 16'(at), 16'h0071);
        check("rst mode", 16'(hit_irq), 16'h0000);
        rd("flag kept", 8'h76);
        gwr(8'h0A);
        rd("flag clr", 8'h0A);
        run(600);
        check("irq time", 16'(at), 16'h0201);
        check("irq mode", 16'(hit_irq), 16'h0001);
        rd("irq flag", 8'h0E);
        $display("test expiry done");
        for (int c = 8; c <= 9; c++) begin
            gwr({4'(c), 4'h2});
            run(4);
            check("imm", 16'(at), 16'h0001);
            check("dl", 16'(hit_dl), 16'(c == 9));
        end
        flash_prot_n = 0;
        gwr(8'h58);
        rd("prot", 8'h52);
        gwr(8'h08);
        rd("forced", 8'h02);
        run(600);
        check("prot rst", 16'({at, hit_irq}), 16'h0402);
        pin_reset();
        rd("pin rst", 8'h72);
        $display("test protect done");
        end_of_test();
    end
endmodule : cwd_watchdog_test
`default_nettype wire
